// [shared/lpmc_pkg.sv]
package lpmc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] STANDBY_CTRL_OFS = 8'h00;
  localparam logic [7:0] IDLE_RUN_OFS = 8'h04;
  localparam logic [7:0] OSC_CTRL_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] PORT_IE_OFS = 8'h10;
  localparam logic [7:0] PORT_OC_OFS = 8'h14;
  localparam logic [7:0] PORT_FS_OFS = 8'h18;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int STBY_LSB = 0;
  localparam int DRIVE_EN_BIT = 8;
  localparam int WAKE_DET_BIT = 9;
  localparam int HIGH_OSC_BIT = 0;
  localparam int LOW_OSC_BIT = 1;
  localparam int SLOW_SEL_BIT = 2;
  localparam int WARM_LSB = 16;
  localparam int DBG_FS_BIT = 8;

  // ------------------------------------------------------------
  // Mode codes and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] STBY_STOP = 3'h1;
  localparam logic [2:0] STBY_SLEEP = 3'h2;
  localparam logic [2:0] STBY_IDLE = 3'h3;
  localparam logic [2:0] STBY_RST = 3'h0;
  localparam logic [4:0] IDLE_RUN_RST = 5'h00;
  localparam logic [15:0] WARM_TICKS_RST = 16'h00C8;
  localparam int NUM_UNITS = 5;
  localparam int NUM_PINS = 8;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WARM_TICK_NS = 1000;
  localparam int WARM_TICK_CYC = (WARM_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    LPMC_RUN,
    LPMC_IDLE,
    LPMC_SLEEP,
    LPMC_STOP,
    LPMC_WARM
  } lpmc_state_e;
endpackage

// [shared/lpmc_wake_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface lpmc_wake_if;
  logic start;
  logic [15:0] ticks;
  logic busy;
  logic done;
  modport ctl (output start, output ticks, input busy, input done);
  modport cnt (input start, input ticks, output busy, output done);
endinterface
`default_nettype wire

// [core/lpmc_warmup.sv]
`timescale 1ns/1ps
`default_nettype none
module lpmc_warmup
  import lpmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  lpmc_wake_if.cnt wake
);
  logic [7:0] divCnt_q;
  logic tick;
  logic [15:0] remain_q;
  logic busy_q;
  logic done_q;

  // ------------------------------------------------------------
  // Tick divider
  // ------------------------------------------------------------
  assign tick = (divCnt_q == 8'(WARM_TICK_CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (rst || wake.start || tick) begin
      divCnt_q <= 8'h00;
    end else begin
      divCnt_q <= divCnt_q + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remain_q <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (wake.start) begin
        remain_q <= wake.ticks;
        busy_q <= 1'b1;
      end else if (busy_q && tick) begin
        // Zero ticks still waits one tick, never skips the wait
        if (remain_q <= 16'h0001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        remain_q <= remain_q - 16'h0001;
      end
    end
  end

  assign wake.busy = busy_q;
  assign wake.done = done_q;
endmodule // lpmc_warmup
`default_nettype wire

// [core/lpmc_top.sv]
// How it works
// RQ1: Software writes mode field, then wait-for-interrupt enters that mode.
// RQ2: Mode codes STOP 001, SLEEP 010, IDLE 011; other writes ignored.
// RQ3: Reset or interrupt releases; interrupt needs detection set up beforehand; IDLE and NMI releases here skip the wake-detect bit.
// RQ4: Wait-for-event never enters a low-power mode; no event wakes it.
// RQ5: Core deep-sleep bit is unused; software must leave it clear.
// RQ6: IDLE stops only the core clock; oscillators, PLL, RTC, ports run.
// RQ7: In IDLE each unit runs only if its run-enable bit is set.
// RQ8: SLEEP keeps low oscillator, RTC, clock generator, ports; returns to prior mode.
// RQ9: STOP halts everything; release returns to prior mode.
// RQ10: STOP pins follow drive-enable; crystal outputs high.
// RQ11: Interrupt input pins stay live in STOP; debug outputs only when valid.
// RQ12: Software stops units before SLOW; they get no clock there.
// RQ13: SLOW never stops the high oscillator; only its enable bit does.
// RQ14: Software sets the debug pin to port use when not debugging.
// RQ15: Leaving STOP, or SLEEP toward NORMAL, runs the warm-up counter first.
// RQ16: Reset returns to NORMAL, clears registers, with no warm-up.
// RQ17: Mode field sampled at wait-for-interrupt sets gating until release.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lpmc_top
  import lpmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic coreWfi,
  input wire logic irqPending,
  input wire logic nmiPin,
  input wire logic dbgDataValid,
  output logic coreClkEn,
  output logic [NUM_UNITS-1:0] unitClkEn,
  output logic pllEn,
  output logic highOscEn,
  output logic lowOscEn,
  output logic rtcClkEn,
  output logic clockGenEn,
  output logic slowClkSel,
  output logic [NUM_PINS-1:0] portInEn,
  output logic [NUM_PINS-1:0] portOutEn,
  output logic xtalOutHigh,
  output logic debugOutEn
);
  lpmc_state_e state_q;
  logic [2:0] stby_q;
  logic driveEn_q;
  logic wakeDetEn_q;
  logic [NUM_UNITS-1:0] idleRun_q;
  logic highOscBit_q;
  logic lowOscBit_q;
  logic slowSel_q;
  logic [15:0] warmTicks_q;
  logic [NUM_PINS-1:0] portIe_q;
  logic [NUM_PINS-1:0] portOc_q;
  logic [NUM_PINS-1:0] intFunc_q;
  logic debugFunc_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic nmiMeta_q;
  logic nmiSync_q;
  logic setup;
  logic wrAccess;
  logic mapped;
  logic [31:0] rdMux;
  logic release_;
  logic running;
  logic inStop;

  lpmc_wake_if wake ();

  lpmc_warmup u_warmup (
    .ref_clk(ref_clk),
    .rst(rst),
    .wake(wake)
  );

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  assign setup = psel && !penable;
  assign wrAccess = psel && penable && pwrite && !pslverr_q;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      STANDBY_CTRL_OFS: begin
        rdMux[STBY_LSB +: 3] = stby_q;
        rdMux[DRIVE_EN_BIT] = driveEn_q;
        rdMux[WAKE_DET_BIT] = wakeDetEn_q;
      end
      IDLE_RUN_OFS: rdMux[NUM_UNITS-1:0] = idleRun_q;
      OSC_CTRL_OFS: begin
        rdMux[HIGH_OSC_BIT] = highOscBit_q;
        rdMux[LOW_OSC_BIT] = lowOscBit_q;
        rdMux[SLOW_SEL_BIT] = slowSel_q;
        rdMux[WARM_LSB +: 16] = warmTicks_q;
      end
      STATUS_OFS: rdMux[3:0] = {wake.busy, state_q};
      PORT_IE_OFS: rdMux[NUM_PINS-1:0] = portIe_q;
      PORT_OC_OFS: rdMux[NUM_PINS-1:0] = portOc_q;
      PORT_FS_OFS: begin
        rdMux[NUM_PINS-1:0] = intFunc_q;
        rdMux[DBG_FS_BIT] = debugFunc_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Answer prepared in setup so data comes straight from a flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
      pslverr_q <= !mapped;
    end
  end

  // RQ16 registers reset: all clear except high osc bit (set) and warm-up ticks (0x00C8)
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stby_q <= STBY_RST;
      driveEn_q <= 1'b0;
      wakeDetEn_q <= 1'b0;
      idleRun_q <= IDLE_RUN_RST;
      highOscBit_q <= 1'b1;
      lowOscBit_q <= 1'b0;
      slowSel_q <= 1'b0;
      warmTicks_q <= WARM_TICKS_RST;
      portIe_q <= '0;
      portOc_q <= '0;
      intFunc_q <= '0;
      debugFunc_q <= 1'b0;
    end else if (wrAccess) begin
      unique case (paddr)
        STANDBY_CTRL_OFS: begin
          // RQ2 illegal codes dropped
          if (pwdata[STBY_LSB +: 3] inside {STBY_STOP, STBY_SLEEP, STBY_IDLE}) begin
            stby_q <= pwdata[STBY_LSB +: 3];
          end
          driveEn_q <= pwdata[DRIVE_EN_BIT];
          wakeDetEn_q <= pwdata[WAKE_DET_BIT];
        end
        IDLE_RUN_OFS: idleRun_q <= pwdata[NUM_UNITS-1:0];
        OSC_CTRL_OFS: begin
          highOscBit_q <= pwdata[HIGH_OSC_BIT];
          lowOscBit_q <= pwdata[LOW_OSC_BIT];
          slowSel_q <= pwdata[SLOW_SEL_BIT];
          warmTicks_q <= pwdata[WARM_LSB +: 16];
        end
        PORT_IE_OFS: portIe_q <= pwdata[NUM_PINS-1:0];
        PORT_OC_OFS: portOc_q <= pwdata[NUM_PINS-1:0];
        PORT_FS_OFS: begin
          intFunc_q <= pwdata[NUM_PINS-1:0];
          debugFunc_q <= pwdata[DBG_FS_BIT];
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Wake sources
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nmiMeta_q <= 1'b0;
      nmiSync_q <= 1'b0;
    end else begin
      nmiMeta_q <= nmiPin;
      nmiSync_q <= nmiMeta_q;
    end
  end

  // RQ3 interrupt release gating
  always_comb begin
    release_ = 1'b0;
    unique case (state_q)
      LPMC_IDLE: release_ = irqPending || nmiSync_q;
      LPMC_SLEEP, LPMC_STOP: release_ = (irqPending && wakeDetEn_q) || nmiSync_q;
      default: release_ = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Mode sequencer
  // ------------------------------------------------------------
  // Prior mode kept in slowSel_q, so release lands back in NORMAL or SLOW
  assign wake.ticks = warmTicks_q;
  // RQ15 auto warm-up start
  assign wake.start = release_ &&
    ((state_q == LPMC_STOP) || (state_q == LPMC_SLEEP && !slowSel_q));

  always_ff @(posedge ref_clk) begin
    // RQ16 reset to NORMAL
    if (rst) begin
      state_q <= LPMC_RUN;
    end else begin
      unique case (state_q)
        // RQ1 entry on wfi
        // RQ17 mode field sampled
        LPMC_RUN: begin
          if (coreWfi) begin
            unique case (stby_q)
              STBY_IDLE: state_q <= LPMC_IDLE;
              STBY_SLEEP: state_q <= LPMC_SLEEP;
              STBY_STOP: state_q <= LPMC_STOP;
              default: state_q <= LPMC_RUN;
            endcase
          end
        end
        LPMC_IDLE: if (release_) state_q <= LPMC_RUN;
        // RQ8 back to prior mode
        // RQ9 back to prior mode
        LPMC_SLEEP, LPMC_STOP: if (release_) state_q <= wake.start ? LPMC_WARM : LPMC_RUN;
        LPMC_WARM: if (wake.done) state_q <= LPMC_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Clock gating
  // ------------------------------------------------------------
  assign running = (state_q == LPMC_RUN);
  assign inStop = (state_q == LPMC_STOP);
  // RQ6 only core halts
  assign coreClkEn = running;
  assign slowClkSel = slowSel_q;
  // Warm-up toward NORMAL (slowSel_q clear) keeps the PLL on so it settles with the oscillator
  assign pllEn = (running && !slowSel_q) || (state_q == LPMC_IDLE) ||
    (state_q == LPMC_WARM && !slowSel_q);
  // RQ13 slow leaves high osc alone
  assign highOscEn = highOscBit_q && (running || state_q == LPMC_IDLE ||
    (state_q == LPMC_WARM && !slowSel_q));
  // RQ8 low osc survives sleep
  assign lowOscEn = lowOscBit_q && !inStop;
  // RQ9 everything stops
  assign rtcClkEn = !inStop;
  assign clockGenEn = !inStop;

  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++) begin : g_unit
      // RQ7 per-unit idle run
      // RQ12 unclocked in slow
      assign unitClkEn[u] = (running && !slowSel_q) || (state_q == LPMC_IDLE && idleRun_q[u]);
    end
  endgenerate

  // ------------------------------------------------------------
  // Pin control
  // ------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      // RQ10 drive-enable pin state
      // RQ11 interrupt inputs stay live
      assign portInEn[p] = portIe_q[p] &&
        (!inStop || driveEn_q || intFunc_q[p]);
      assign portOutEn[p] = portOc_q[p] && (!inStop || driveEn_q);
    end
  endgenerate

  // RQ10 crystal outputs high
  assign xtalOutHigh = inStop;
  // RQ11 debug drive when valid
  assign debugOutEn = debugFunc_q && (!inStop || dbgDataValid);
endmodule // lpmc_top
`default_nettype wire

// [test/lpmc_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module lpmc_monitor
  import lpmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic coreWfi,
  input wire logic nmiPin,
  input wire logic dbgDataValid,
  input wire logic coreClkEn,
  input wire logic [NUM_UNITS-1:0] unitClkEn,
  input wire logic pllEn,
  input wire logic highOscEn,
  input wire logic lowOscEn,
  input wire logic rtcClkEn,
  input wire logic clockGenEn,
  input wire logic slowClkSel,
  input wire logic xtalOutHigh,
  input wire logic debugOutEn
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_stop_all_off: assert property (
    !clockGenEn |-> !rtcClkEn && !coreClkEn && !pllEn && !highOscEn && !lowOscEn
    && unitClkEn == '0) else $error("clock left running in stop");
  a_stop_xtal_high: assert property (xtalOutHigh ^ clockGenEn)
    else $error("crystal output level wrong");
  a_stop_debug_gate: assert property (
    !clockGenEn && !dbgDataValid |-> !debugOutEn) else $error("debug driven while invalid");
  a_sleep_gates: assert property (
    clockGenEn && !coreClkEn && !pllEn |-> unitClkEn == '0 && !highOscEn && rtcClkEn)
    else $error("sleep gating wrong");
  a_run_units_on: assert property (
    coreClkEn && !slowClkSel |-> unitClkEn == '1 && pllEn) else $error("run gating wrong");
  a_slow_no_clk: assert property (
    coreClkEn && slowClkSel |-> !pllEn && unitClkEn == '0) else $error("slow gating wrong");
  a_core_stays_on: assert property (
    coreClkEn && !coreWfi |=> coreClkEn) else $error("core stopped without wfi");
  a_nmi_release: assert property (
    $rose(nmiPin) && !clockGenEn |-> ##[1:5] clockGenEn) else $error("nmi did not release");
  a_warm_core_off: assert property (
    $rose(clockGenEn) && !$past(rst) |-> !coreClkEn [*8]) else $error("core clock before warm-up");
  a_reset_normal: assert property (disable iff (1'b0)
    rst |=> coreClkEn && pllEn && clockGenEn && !lowOscEn) else $error("reset not normal");
endmodule // lpmc_monitor
bind lpmc_top lpmc_monitor u_mon (.ref_clk, .rst, .coreWfi, .nmiPin, .dbgDataValid,
  .coreClkEn, .unitClkEn, .pllEn, .highOscEn, .lowOscEn, .rtcClkEn, .clockGenEn,
  .slowClkSel, .xtalOutHigh, .debugOutEn);
`default_nettype wire

// [test/lpmc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sleepCmd,
  input wire logic wakeCmd,
  input wire logic coreClkEn,
  output logic coreWfi,
  output logic irqPending
);
  // only wfi, never event or deep-sleep
  always_ff @(posedge ref_clk) begin
    coreWfi <= !rst && sleepCmd && coreClkEn;
  end
  // level held until the core runs again
  always_ff @(posedge ref_clk) begin
    irqPending <= !rst && (wakeCmd || (irqPending && !coreClkEn));
  end
endmodule // lpmc_core_model
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lpmc_pkg::*;
;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic nmiPin = 0, dbgDataValid = 0, sleepCmd = 0, wakeCmd = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, coreWfi, irqPending, coreClkEn, pllEn, highOscEn, lowOscEn;
  logic rtcClkEn, clockGenEn, slowClkSel, xtalOutHigh, debugOutEn;
  logic [4:0] unitClkEn;
  logic [7:0] portInEn, portOutEn;
  int bad_count = 0, n_tests = 0;
  lpmc_top u_lpmc_top (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .coreWfi, .irqPending, .nmiPin, .dbgDataValid, .coreClkEn,
    .unitClkEn, .pllEn, .highOscEn, .lowOscEn, .rtcClkEn, .clockGenEn, .slowClkSel,
    .portInEn, .portOutEn, .xtalOutHigh, .debugOutEn);
  lpmc_core_model u_lpmc_core_model (.ref_clk, .rst, .sleepCmd, .wakeCmd, .coreClkEn,
    .coreWfi, .irqPending);
  always #5 ref_clk = ~ref_clk;
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      chk("pready", pready, 1);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task enter(input logic [31:0] ctl);
    apb(1'b1, STANDBY_CTRL_OFS, ctl);
    sleepCmd <= 1'b1;
    @(posedge ref_clk);
    sleepCmd <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task wake;
    wakeCmd <= 1'b1;
    @(posedge ref_clk);
    wakeCmd <= 1'b0;
  endtask
  task wait_core;
    int i;
    for (i = 0; i < 400 && coreClkEn !== 1'b1; i++) @(posedge ref_clk);
    chk("core clock back", 32'(coreClkEn), 1);
    if (coreClkEn !== 1'b1) finish_test();
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, OSC_CTRL_OFS, 0);
    chk("osc ctrl reset", rd, 32'h00C8_0001);
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, STANDBY_CTRL_OFS, 32'h0000_0003);
      apb(1'b1, STANDBY_CTRL_OFS, 32'(m));
      apb(1'b0, STANDBY_CTRL_OFS, 0);
      chk("mode field", 32'(rd[2:0]), (m inside {1, 2, 3}) ? 32'(m) : 3);
    end
    apb(1'b0, 8'h1C, 0);
    chk("unmapped", {rd[30:0], err}, 1);
    $display("test registers done");
    apb(1'b1, IDLE_RUN_OFS, 32'h0000_0015);
    enter(32'(STBY_IDLE));
    chk("idle clocks", 32'({coreClkEn, unitClkEn, pllEn, highOscEn, rtcClkEn}), 32'h0000_00AF);
    wake();
    wait_core();
    $display("test idle done");
    apb(1'b1, OSC_CTRL_OFS, 32'h0001_0003);
    enter(32'h0000_0200 | STBY_SLEEP);
    chk("sleep clocks", 32'({coreClkEn, unitClkEn, pllEn, highOscEn, lowOscEn, rtcClkEn}), 3);
    wake();
    repeat (50) @(posedge ref_clk);
    apb(1'b0, STATUS_OFS, 0);
    chk("warm status", rd, 32'h0000_000C);
    wait_core();
    apb(1'b1, OSC_CTRL_OFS, 32'h0001_0007);
    // Let the slow select write land before looking
    @(posedge ref_clk);
    chk("slow high osc", 32'(highOscEn), 1);
    enter(32'h0000_0200 | STBY_SLEEP);
    wake();
    repeat (3) @(posedge ref_clk);
    chk("slow resume", 32'({coreClkEn, slowClkSel, pllEn}), 6);
    apb(1'b1, OSC_CTRL_OFS, 32'h0001_0003);
    $display("test sleep done");
    apb(1'b1, PORT_IE_OFS, 32'h0000_00FF);
    apb(1'b1, PORT_OC_OFS, 32'h0000_00FF);
    apb(1'b1, PORT_FS_OFS, 32'h0000_0101);
    enter(32'(STBY_STOP));
    chk("stop pins", 32'({portInEn, portOutEn, xtalOutHigh, debugOutEn}), 32'h0000_0402);
    dbgDataValid <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("debug valid", 32'(debugOutEn), 1);
    wake();
    repeat (10) @(posedge ref_clk);
    chk("irq without detect", 32'(clockGenEn), 0);
    nmiPin <= 1'b1;
    wait_core();
    nmiPin <= 1'b0;
    dbgDataValid <= 1'b0;
    apb(1'b1, PORT_FS_OFS, 32'h0000_0001);
    enter(32'h0000_0100 | STBY_STOP);
    chk("drive pins", 32'({portInEn, portOutEn}), 32'h0000_FFFF);
    chk("debug released", 32'(debugOutEn), 0);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("reset run", 32'(coreClkEn), 1);
    apb(1'b0, STANDBY_CTRL_OFS, 0);
    chk("ctrl cleared", rd, 0);
    $display("test stop done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
